//--- inc/dmpp_pkg.sv
package dmpp_pkg;

  // ******************************************************
  // page identity
  // ******************************************************
  localparam logic [5:0] PAGE_VENDOR_CODE   = 6'h00;
  localparam logic [5:0] PAGE_RECOVERY_CODE = 6'h01;
  localparam logic [7:0] PAGE_VENDOR_LEN    = 8'h0e;
  localparam logic [7:0] PAGE_RECOVERY_LEN  = 8'h0a;
  localparam logic       PAGE_SAVABLE       = 1'h1;
  localparam int         VENDOR_BYTES       = 16;
  localparam int         RECOVERY_BYTES     = 12;

  // ******************************************************
  // byte offsets inside the pages
  // ******************************************************
  localparam logic [3:0] OFS_RECOVERY_FLAGS     = 4'h2;
  localparam logic [3:0] OFS_READ_RETRY_LIMIT   = 4'h3;
  localparam logic [3:0] OFS_REPORT_AGING_FLAGS = 4'h5;
  localparam logic [3:0] OFS_DEADLINE_HIGH      = 4'h6;
  localparam logic [3:0] OFS_DEADLINE_LOW       = 4'h7;
  localparam logic [3:0] OFS_WRITE_RETRY_LIMIT  = 4'h8;
  localparam logic [3:0] OFS_THERMAL_LEVEL      = 4'h9;
  localparam logic [3:0] OFS_AGE_LIMIT_HIGH     = 4'ha;
  localparam logic [3:0] OFS_RECOVERY_TIME_CAP  = 4'ha;
  localparam logic [3:0] OFS_AGE_LIMIT_LOW      = 4'hb;
  localparam logic [3:0] OFS_INJECT_REPORT      = 4'hc;
  localparam logic [3:0] OFS_FORMAT_OPTIONS     = 4'hf;

  // ******************************************************
  // field positions
  // ******************************************************
  localparam int BIT_FORMAT_DEGRADED_QUIET = 4;
  localparam int BIT_QUEUE_AGE_ENABLE      = 1;
  localparam int BIT_PSEUDO_ERROR_ACTIVE   = 7;
  localparam int BIT_FORMAT_VERIFY_STEP    = 5;
  localparam int BIT_RECOVERED_ERROR_POST  = 2;
  localparam int BIT_EARLY_RECOVERY_FLAG   = 3;
  localparam int REPORT_LEVEL_MSB          = 4;

  // ******************************************************
  // reset values
  // ******************************************************
  localparam logic [7:0] RST_REPORT_AGING_FLAGS = 8'h02;
  localparam logic [7:0] RST_AGE_LIMIT_LOW      = 8'h30;
  localparam logic [7:0] RST_INJECT_REPORT      = 8'h16;
  localparam logic [7:0] RST_IGNORED            = 8'h00;

  // ******************************************************
  // limits and timing
  // ******************************************************
  localparam logic [4:0] REPORT_LEVEL_MIN     = 5'h03;
  localparam logic [4:0] REPORT_LEVEL_MAX     = 5'h17;
  localparam logic [7:0] THERMAL_DEFAULT_C    = 8'h46;
  localparam int         TICK_MS              = 50;
  localparam int         CLK_MHZ              = 200;
  localparam int         TICK_CYCLES          = TICK_MS * 1000 * CLK_MHZ;

  // ******************************************************
  // mode select sequencer
  // ******************************************************
  typedef enum logic [2:0] {
    DMPP_SEL_IDLE = 3'b001,
    DMPP_SEL_LOAD = 3'b010,
    DMPP_SEL_FAIL = 3'b100
  } dmpp_sel_e;

endpackage

//--- verilog/dmpp_mode_pages.sv
// Behaviour
// - tur degraded sense hidden when quiet bit set
// - media commands always report degraded format
// - aged queue forces first come first served
// - age enable clear keeps normal reordering
// - age limit sixteen bits, 50 ms units
// - deadline expiry aborts running command
// - deadline twelve bits, zero disables it
// - deadline independent of aging and recovery
// - thermal warning threshold, zero means seventy
// - injection status bit is read only
// - format command selects pseudo error injection
// - recovered error only above threshold 3..23
// - post bit gates recovered error reports
// - format verify step runs certification
// - ignored fields accepted, reset to zero
// - reallocation always on for reads, writes
// - read recovery always, retry fields ignored
// - recovery parameters apply to media commands
// - page length mismatch fails mode select
module dmpp_mode_pages
  import dmpp_pkg::*;
#(
  parameter int TICK_COUNT = TICK_CYCLES
) (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       sel_start,
  input  wire logic       sel_we,
  input  wire logic       sel_page,
  input  wire logic [3:0] sel_idx,
  input  wire logic [7:0] sel_wdata,
  input  wire logic       sel_end,
  output logic            sel_done,
  output logic            sel_check,
  input  wire logic       sense_re,
  input  wire logic       sense_page,
  input  wire logic [3:0] sense_idx,
  output logic [7:0]      sense_rdata,
  output logic            sense_valid,
  input  wire logic       cmd_start,
  input  wire logic       cmd_done,
  output logic            cmd_abort,
  input  wire logic       queue_busy,
  input  wire logic       queue_oldest_issued,
  output logic            queue_fifo_order,
  input  wire logic [7:0] thermal_c,
  output logic            thermal_warn,
  input  wire logic       format_degraded,
  input  wire logic       cmd_is_tur,
  input  wire logic       cmd_is_media,
  output logic            degraded_report,
  input  wire logic       bit_err_valid,
  input  wire logic [4:0] bit_err_count,
  output logic            recovered_report,
  input  wire logic       format_start,
  input  wire logic       pseudo_error_select,
  output logic            format_certify,
  output logic            pseudo_error_inject,
  output logic            read_realloc_on,
  output logic            write_realloc_on,
  output logic            read_recovery_on
);

  // ******************************************************
  // state
  // ******************************************************
  typedef struct packed {
    dmpp_sel_e                          sel;
    logic                               sel_page;
    logic                               done;
    logic                               check;
    logic [VENDOR_BYTES-1:0][7:0]       vend;
    logic [RECOVERY_BYTES-1:0][7:0]     recv;
    logic [7:0]                         rdata;
    logic                               rvalid;
    logic [31:0]                        tick_cnt;
    logic                               tick;
    logic                               cmd_busy;
    logic [11:0]                        cmd_age;
    logic                               abort;
    logic [15:0]                        q_age;
    logic                               thermal;
    logic                               degraded;
    logic                               recovered;
    logic                               inject;
  } dmpp_state_s;

  dmpp_state_s s_q;
  dmpp_state_s s_d;

  // ******************************************************
  // decode helpers
  // ******************************************************
  function automatic logic [7:0] page_len(input logic page);
    page_len = page ? PAGE_RECOVERY_LEN : PAGE_VENDOR_LEN;
  endfunction

  function automatic logic idx_in_page(input logic page, input logic [3:0] idx);
    idx_in_page = page ? (32'(idx) < RECOVERY_BYTES) : 1'b1;
  endfunction

  function automatic logic [7:0] page_head(input logic page);
    page_head = {PAGE_SAVABLE, 1'b0, page ? PAGE_RECOVERY_CODE : PAGE_VENDOR_CODE};
  endfunction

  logic [11:0] deadline;
  logic [15:0] age_limit;
  logic [7:0]  thermal_level;
  logic [4:0]  report_level;
  logic        quiet;
  logic        age_en;
  logic        post;
  logic        value_bad;

  always_comb begin
    deadline      = {s_q.vend[OFS_DEADLINE_HIGH][3:0], s_q.vend[OFS_DEADLINE_LOW]};
    age_limit     = {s_q.vend[OFS_AGE_LIMIT_HIGH], s_q.vend[OFS_AGE_LIMIT_LOW]};
    thermal_level = (s_q.vend[OFS_THERMAL_LEVEL] == 8'h00) ? THERMAL_DEFAULT_C
                                                           : s_q.vend[OFS_THERMAL_LEVEL];
    report_level  = s_q.vend[OFS_INJECT_REPORT][REPORT_LEVEL_MSB:0];
    quiet         = s_q.vend[OFS_REPORT_AGING_FLAGS][BIT_FORMAT_DEGRADED_QUIET];
    age_en        = s_q.vend[OFS_REPORT_AGING_FLAGS][BIT_QUEUE_AGE_ENABLE];
    post          = s_q.recv[OFS_RECOVERY_FLAGS][BIT_RECOVERED_ERROR_POST];
    // threshold bytes outside 3..23 are refused
    value_bad     = !s_q.sel_page && sel_idx == OFS_INJECT_REPORT &&
                    (sel_wdata[REPORT_LEVEL_MSB:0] < REPORT_LEVEL_MIN ||
                     sel_wdata[REPORT_LEVEL_MSB:0] > REPORT_LEVEL_MAX);
  end

  // ******************************************************
  // next state
  // ******************************************************
  always_comb begin
    s_d        = s_q;
    s_d.done   = 1'b0;
    s_d.rvalid = 1'b0;
    s_d.abort  = 1'b0;
    s_d.recovered = 1'b0;

    // mode select byte stream
    unique case (s_q.sel)
      DMPP_SEL_IDLE: begin
        if (sel_start) begin
          s_d.sel      = DMPP_SEL_LOAD;
          s_d.sel_page = sel_page;
          s_d.check    = 1'b0;
        end
      end
      DMPP_SEL_LOAD: begin
        if (sel_end) begin
          s_d.sel   = DMPP_SEL_IDLE;
          s_d.done  = 1'b1;
        end else if (sel_we && sel_idx == 4'h1) begin
          if (sel_wdata != page_len(s_q.sel_page)) begin
            s_d.sel = DMPP_SEL_FAIL;
          end
        end else if (sel_we && sel_idx > 4'h1 && value_bad) begin
          s_d.sel = DMPP_SEL_FAIL;
        end else if (sel_we && sel_idx > 4'h1 && idx_in_page(s_q.sel_page, sel_idx)) begin
          // bytes are stored as written, ignored fields too, except the pseudo error status bit and the early recovery flag
          if (s_q.sel_page) begin
            s_d.recv[sel_idx] = sel_wdata;
            s_d.recv[OFS_RECOVERY_FLAGS][BIT_EARLY_RECOVERY_FLAG] =
              (sel_idx == OFS_RECOVERY_FLAGS) ? 1'b0 : s_q.recv[OFS_RECOVERY_FLAGS][BIT_EARLY_RECOVERY_FLAG];
          end else if (sel_idx == OFS_INJECT_REPORT) begin
            s_d.vend[sel_idx] = {s_q.vend[sel_idx][BIT_PSEUDO_ERROR_ACTIVE],
                                 sel_wdata[BIT_PSEUDO_ERROR_ACTIVE-1:0]};
          end else begin
            s_d.vend[sel_idx] = sel_wdata;
          end
        end
      end
      DMPP_SEL_FAIL: begin
        if (sel_end) begin
          s_d.sel   = DMPP_SEL_IDLE;
          s_d.done  = 1'b1;
          s_d.check = 1'b1;
        end
      end
      default: s_d.sel = DMPP_SEL_IDLE;
    endcase

    // mode sense read
    if (sense_re) begin
      s_d.rvalid = 1'b1;
      if (sense_idx == 4'h0) begin
        s_d.rdata = page_head(sense_page);
      end else if (sense_idx == 4'h1) begin
        s_d.rdata = page_len(sense_page);
      end else if (!idx_in_page(sense_page, sense_idx)) begin
        s_d.rdata = 8'h00;
      end else begin
        s_d.rdata = sense_page ? s_q.recv[sense_idx] : s_q.vend[sense_idx];
      end
    end

    // shared 50 ms tick
    s_d.tick = 1'b0;
    if (s_q.tick_cnt == 32'(TICK_COUNT - 1)) begin
      s_d.tick_cnt = 32'h0;
      s_d.tick     = 1'b1;
    end else begin
      s_d.tick_cnt = s_q.tick_cnt + 32'h1;
    end

    // per command deadline
    if (cmd_start) begin
      s_d.cmd_busy = 1'b1;
      s_d.cmd_age  = 12'h000;
    end else if (cmd_done) begin
      s_d.cmd_busy = 1'b0;
    end else if (s_q.cmd_busy && deadline != 12'h000) begin
      if (s_q.cmd_age >= deadline) begin
        s_d.abort    = 1'b1;
        s_d.cmd_busy = 1'b0;
      end else if (s_q.tick) begin
        s_d.cmd_age = s_q.cmd_age + 12'h001;
      end
    end

    // oldest command age
    if (!queue_busy || queue_oldest_issued) begin
      s_d.q_age = 16'h0000;
    end else if (s_q.tick && s_q.q_age != 16'hffff) begin
      s_d.q_age = s_q.q_age + 16'h0001;
    end

    s_d.thermal  = thermal_c > thermal_level;
    s_d.degraded = format_degraded && (cmd_is_media || (cmd_is_tur && !quiet));
    s_d.recovered = bit_err_valid && cmd_is_media && post && (bit_err_count > report_level);

    if (format_start) begin
      s_d.inject = pseudo_error_select;
      s_d.vend[OFS_INJECT_REPORT][BIT_PSEUDO_ERROR_ACTIVE] = pseudo_error_select;
    end
  end

  // ******************************************************
  // registers
  // ******************************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_q                         <= '0;
      s_q.sel                     <= DMPP_SEL_IDLE;
      s_q.vend[OFS_REPORT_AGING_FLAGS] <= RST_REPORT_AGING_FLAGS;
      s_q.vend[OFS_AGE_LIMIT_LOW] <= RST_AGE_LIMIT_LOW;
      s_q.vend[OFS_INJECT_REPORT] <= RST_INJECT_REPORT;
    end else begin
      s_q <= s_d;
    end
  end

  // ******************************************************
  // outputs
  // ******************************************************
  assign sel_done            = s_q.done;
  assign sel_check           = s_q.check;
  assign sense_rdata         = s_q.rdata;
  assign sense_valid         = s_q.rvalid;
  assign cmd_abort           = s_q.abort;
  assign queue_fifo_order    = age_en && (s_q.q_age > age_limit);
  assign thermal_warn        = s_q.thermal;
  assign degraded_report     = s_q.degraded;
  assign recovered_report    = s_q.recovered;
  assign format_certify      = s_q.vend[OFS_FORMAT_OPTIONS][BIT_FORMAT_VERIFY_STEP];
  assign pseudo_error_inject = s_q.inject;
  assign read_realloc_on     = 1'b1;
  assign write_realloc_on    = 1'b1;
  assign read_recovery_on    = 1'b1;

  // ******************************************************
  // checks
  // ******************************************************
  default clocking dmpp_cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  a_tur_quiet_hide: assert property (
    format_degraded && cmd_is_tur && !cmd_is_media && quiet |=> !degraded_report)
    else $error("degraded sense reported for tur while quiet");

  a_media_degraded_rep: assert property (
    format_degraded && cmd_is_media |=> degraded_report)
    else $error("degraded format not reported for media command");

  a_age_disable_order: assert property (
    !age_en |-> !queue_fifo_order)
    else $error("fifo order forced with aging disabled");

  a_age_limit_order: assert property (
    age_en && s_q.q_age > age_limit |-> queue_fifo_order)
    else $error("aged queue not forced to fifo order");

  a_deadline_abort_gate: assert property (
    cmd_abort |-> deadline != 12'h000 && $past(s_q.cmd_busy))
    else $error("abort without armed deadline");

  a_deadline_abort_fire: assert property (
    s_q.cmd_busy && deadline != 12'h000 && s_q.cmd_age >= deadline && !cmd_start && !cmd_done
    |=> cmd_abort ##1 !cmd_abort)
    else $error("expired deadline did not abort once");

  a_thermal_default: assert property (
    s_q.vend[OFS_THERMAL_LEVEL] == 8'h00 && thermal_c == 8'h47 |=> thermal_warn)
    else $error("default thermal threshold not used");

  a_recovered_gate: assert property (
    recovered_report |-> $past(post) && $past(bit_err_count) > $past(report_level))
    else $error("recovered error reported without post or threshold");

  a_length_check: assert property (
    s_q.sel == DMPP_SEL_LOAD && sel_we && !sel_end && sel_idx == 4'h1 && sel_wdata != page_len(s_q.sel_page)
    |=> s_q.sel == DMPP_SEL_FAIL)
    else $error("page length mismatch not caught");

  a_fail_check_out: assert property (
    s_q.sel == DMPP_SEL_FAIL && sel_end |=> sel_done && sel_check)
    else $error("failed mode select not reported");

  a_inject_status: assert property (
    format_start |=> s_q.vend[OFS_INJECT_REPORT][BIT_PSEUDO_ERROR_ACTIVE] == $past(pseudo_error_select)
                     && pseudo_error_inject == $past(pseudo_error_select))
    else $error("injection status does not follow format command");

  a_tur_report_on: assert property (
    format_degraded && cmd_is_tur && !quiet |=> degraded_report)
    else $error("degraded format not reported for tur");

  a_age_idle_clear: assert property (
    !queue_busy |=> !queue_fifo_order)
    else $error("fifo order forced with empty queue");

  a_deadline_off: assert property (
    deadline == 12'h000 |=> !cmd_abort)
    else $error("abort while deadline disabled");

  a_done_cancel: assert property (
    cmd_done && !cmd_start |=> !cmd_abort)
    else $error("abort after command completed");

  a_thermal_below: assert property (
    s_q.vend[OFS_THERMAL_LEVEL] != 8'h00 && thermal_c <= s_q.vend[OFS_THERMAL_LEVEL] |=> !thermal_warn)
    else $error("thermal warning at or below threshold");

  a_inject_readonly: assert property (
    !format_start |=> $stable(s_q.vend[OFS_INJECT_REPORT][BIT_PSEUDO_ERROR_ACTIVE]))
    else $error("injection status changed without format command");

  a_report_level_range: assert property (
    report_level >= REPORT_LEVEL_MIN && report_level <= REPORT_LEVEL_MAX)
    else $error("report threshold outside legal range");

  a_recovered_post_off: assert property (
    !post |=> !recovered_report)
    else $error("recovered error reported with post clear");

  a_certify_set: assert property (
    s_q.sel == DMPP_SEL_LOAD && sel_we && !sel_end && !s_q.sel_page && sel_idx == OFS_FORMAT_OPTIONS
    && sel_wdata[BIT_FORMAT_VERIFY_STEP] |=> format_certify)
    else $error("format verify step not stored");

  a_early_rec_zero: assert property (
    !s_q.recv[OFS_RECOVERY_FLAGS][BIT_EARLY_RECOVERY_FLAG])
    else $error("early recovery flag reads one");

  a_recovered_media: assert property (
    !cmd_is_media |=> !recovered_report)
    else $error("recovered error reported outside media command");

  a_done_after_end: assert property (
    s_q.sel != DMPP_SEL_IDLE && sel_end |=> sel_done)
    else $error("mode select end not answered");

  c_select_ok: cover property (s_q.sel == DMPP_SEL_LOAD ##[1:40] sel_done && !sel_check);
  c_select_fail: cover property (sel_done && sel_check);
  c_deadline_abort: cover property (cmd_abort);
  c_fifo_forced: cover property (queue_fifo_order);
  c_recovered_post: cover property (recovered_report);

endmodule

//--- sim/dmpp_host_model.sv
// ****************************************
// host initiator issuing page writes and reads
// ****************************************
module dmpp_host_model
  import dmpp_pkg::*;
(
  input  wire logic       core_clk,
  output logic            sel_start,
  output logic            sel_we,
  output logic            sel_page,
  output logic [3:0]      sel_idx,
  output logic [7:0]      sel_wdata,
  output logic            sel_end,
  input  wire logic       sel_done,
  input  wire logic       sel_check,
  output logic            sense_re,
  output logic            sense_page,
  output logic [3:0]      sense_idx,
  input  wire logic [7:0] sense_rdata,
  input  wire logic       sense_valid
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    {sel_start, sel_we, sel_page, sel_idx, sel_wdata, sel_end} = '0;
    {sense_re, sense_page, sense_idx} = '0;
  end

  // length byte first, then one field byte
  task automatic sel_cmd(input logic page, input logic [7:0] len, input logic [3:0] idx,
                         input logic [7:0] data, output logic chk, output logic ok);
    ok  = 1'b0;
    chk = 1'b0;
    @(negedge core_clk);
    sel_start = 1'b1;
    sel_page  = page;
    @(negedge core_clk);
    sel_start = 1'b0;
    sel_we    = 1'b1;
    sel_idx   = 4'h1;
    sel_wdata = len;
    @(negedge core_clk);
    sel_idx   = idx;
    sel_wdata = data;
    @(negedge core_clk);
    sel_we    = 1'b0;
    sel_end   = 1'b1;
    sel_wdata = ~data;
    @(negedge core_clk);
    sel_end   = 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      if (sel_done === 1'b1) begin
        ok  = 1'b1;
        chk = sel_check;
      end else begin
        @(negedge core_clk);
      end
    end
  endtask

  task automatic sense_byte(input logic page, input logic [3:0] idx, output logic [7:0] data, output logic ok);
    ok = 1'b0;
    @(negedge core_clk);
    sense_re   = 1'b1;
    sense_page = page;
    sense_idx  = idx;
    @(negedge core_clk);
    sense_re  = 1'b0;
    sense_idx = ~idx;
    data      = sense_rdata;
    ok        = (sense_valid === 1'b1);
  endtask
endmodule

//--- sim/tb_drive_mode_page_policy.sv
module tb_drive_mode_page_policy
  import dmpp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic       core_clk = 1'b0;
  logic       resetn   = 1'b0;
  logic       sel_start, sel_we, sel_page, sel_end, sel_done, sel_check;
  logic [3:0] sel_idx, sense_idx;
  logic [7:0] sel_wdata, sense_rdata;
  logic       sense_re, sense_page, sense_valid;
  logic       cmd_start = 1'b0, cmd_done = 1'b0, cmd_abort, queue_fifo_order;
  logic       queue_busy = 1'b0, queue_oldest_issued = 1'b0;
  logic [7:0] thermal_c = 8'h00;
  logic       thermal_warn, format_degraded = 1'b0, cmd_is_tur = 1'b0, cmd_is_media = 1'b0, degraded_report;
  logic       bit_err_valid = 1'b0, recovered_report, format_start = 1'b0, pseudo_error_select = 1'b0;
  logic [4:0] bit_err_count = 5'h00;
  logic       format_certify, pseudo_error_inject, read_realloc_on, write_realloc_on, read_recovery_on;
  int         n_mismatch = 0;
  int         total_checks = 0;

  always #2.5 core_clk = ~core_clk;

  dmpp_mode_pages #(.TICK_COUNT(4)) uut (.*);
  dmpp_host_model host (.*);

  // ****************************************
  // compare and access helpers
  // ****************************************
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask

  task automatic sel(input logic pg, input logic [3:0] idx, input logic [7:0] d, input logic exp_chk,
                     input logic [7:0] len = 8'h00);
    logic c, ok;
    host.sel_cmd(pg, (len != 0) ? len : (pg ? PAGE_RECOVERY_LEN : PAGE_VENDOR_LEN), idx, d, c, ok);
    chk1(ok, 1'b1);
    chk1(c, exp_chk);
  endtask

  task automatic rd(input logic pg, input logic [3:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host.sense_byte(pg, idx, d, ok);
    chk1(ok, 1'b1);
    chk8(d, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    rd(0, 4'h0, 8'h80);
    rd(0, 4'h1, 8'h0e);
    rd(0, 4'h5, 8'h02);
    rd(0, 4'hb, 8'h30);
    rd(0, 4'hc, 8'h16);
    rd(0, 4'h2, 8'h00);
    rd(1, 4'h0, 8'h81);
    rd(1, 4'h1, 8'h0a);
    chk1(read_realloc_on & write_realloc_on, 1'b1);
    chk1(read_recovery_on, 1'b1);
    sel(0, 4'h3, 8'h5a, 1'b0);
    rd(0, 4'h3, 8'h5a);
  endtask

  task automatic t_degraded;
    format_degraded = 1'b1;
    cmd_is_tur      = 1'b1;
    cyc(2);
    chk1(degraded_report, 1'b1);
    sel(0, 4'h5, 8'h12, 1'b0);
    cyc(2);
    chk1(degraded_report, 1'b0);
    cmd_is_tur   = 1'b0;
    cmd_is_media = 1'b1;
    cyc(2);
    chk1(degraded_report, 1'b1);
    format_degraded = 1'b0;
    cyc(2);
    chk1(degraded_report, 1'b0);
  endtask

  task automatic t_aging;
    sel(0, 4'ha, 8'h00, 1'b0);
    sel(0, 4'hb, 8'h02, 1'b0);
    queue_busy = 1'b1;
    cyc(6);
    chk1(queue_fifo_order, 1'b0);
    cyc(14);
    chk1(queue_fifo_order, 1'b1);
    queue_oldest_issued = 1'b1;
    cyc(1);
    queue_oldest_issued = 1'b0;
    cyc(1);
    chk1(queue_fifo_order, 1'b0);
    sel(0, 4'h5, 8'h10, 1'b0);
    cyc(20);
    chk1(queue_fifo_order, 1'b0);
    queue_busy = 1'b0;
  endtask

  task automatic run_cmd(input int done_at, output int abort_at);
    abort_at = 0;
    cmd_start = 1'b1;
    cyc(1);
    cmd_start = 1'b0;
    for (int i = 1; i < 30; i++) begin
      cmd_done = (i == done_at);
      if (cmd_abort === 1'b1 && abort_at == 0) abort_at = i;
      cyc(1);
    end
    cmd_done = 1'b0;
  endtask

  task automatic t_deadline;
    int at;
    sel(0, 4'h6, 8'h00, 1'b0);
    sel(0, 4'h7, 8'h02, 1'b0);
    run_cmd(0, at);
    chk1(at >= 5 && at <= 10, 1'b1);
    run_cmd(2, at);
    chk8(at[7:0], 8'h00);
    sel(0, 4'h7, 8'h00, 1'b0);
    run_cmd(0, at);
    chk8(at[7:0], 8'h00);
  endtask

  task automatic t_thermal;
    thermal_c = 8'h46;
    cyc(2);
    chk1(thermal_warn, 1'b0);
    thermal_c = 8'h47;
    cyc(2);
    chk1(thermal_warn, 1'b1);
    sel(0, 4'h9, 8'h30, 1'b0);
    thermal_c = 8'h30;
    cyc(2);
    chk1(thermal_warn, 1'b0);
    thermal_c = 8'h31;
    cyc(2);
    chk1(thermal_warn, 1'b1);
  endtask

  task automatic err(input logic [4:0] n, input logic exp);
    bit_err_valid = 1'b1;
    bit_err_count = n;
    cyc(1);
    bit_err_valid = 1'b0;
    bit_err_count = ~n;
    chk1(recovered_report, exp);
    // let an edge pass so a following call does not re-raise the strobe in this step
    cyc(1);
  endtask

  task automatic t_recovered;
    sel(1, 4'h2, 8'h0c, 1'b0);
    rd(1, 4'h2, 8'h04);
    sel(0, 4'hc, 8'h05, 1'b0);
    err(5'h05, 1'b0);
    err(5'h06, 1'b1);
    cmd_is_media = 1'b0;
    err(5'h06, 1'b0);
    cmd_is_media = 1'b1;
    sel(1, 4'h2, 8'h00, 1'b0);
    err(5'h17, 1'b0);
    sel(0, 4'hc, 8'h02, 1'b1);
    rd(0, 4'hc, 8'h05);
    sel(0, 4'h9, 8'h44, 1'b1, 8'h0d);
    rd(0, 4'h9, 8'h30);
  endtask

  task automatic t_format;
    chk1(pseudo_error_inject, 1'b0);
    format_start        = 1'b1;
    pseudo_error_select = 1'b1;
    cyc(1);
    format_start = 1'b0;
    cyc(1);
    chk1(pseudo_error_inject, 1'b1);
    rd(0, 4'hc, 8'h85);
    sel(0, 4'hc, 8'h05, 1'b0);
    rd(0, 4'hc, 8'h85);
    sel(0, 4'hf, 8'h20, 1'b0);
    chk1(format_certify, 1'b1);
    sel(0, 4'hf, 8'h00, 1'b0);
    chk1(format_certify, 1'b0);
    format_start        = 1'b1;
    pseudo_error_select = 1'b0;
    cyc(1);
    format_start = 1'b0;
    cyc(1);
    chk1(pseudo_error_inject, 1'b0);
    rd(0, 4'hc, 8'h05);
  endtask

  initial begin
    cyc(6);
    resetn = 1'b1;
    t_reset();
    t_degraded();
    t_aging();
    t_deadline();
    t_thermal();
    t_recovered();
    t_format();
    print_verdict();
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    print_verdict();
  end
endmodule
